// ==== logic/rssr_cfg.svh ====
/*
  Constants of the reader status and debug register group: register
  offsets, field positions, reset values and timing counts.
  Assumes a 100 MHz core clock and a 5-bit host register address.
*/
//
// Functional notes
// R1: strength values stay valid from reception start until next transmit
// R2: strength tracks envelope, or RF amplitude while that command runs
// R3: highest strength seen during reception is held for later reading
// R4: latched strength values clear when the reader next transmits
// R5: each strength is a 3-bit code, seven steps of 4 dB
// R6: main strength in bits 2..0, auxiliary in bits 5..3, MSB high; code reads bit 7 as zero
// R7: bit 6 shows oscillator stable, about 200 us after start
// R8: auxiliary field measures aux input, or main input when swapped
// R9: ook pin feeds the decoder input when bit 7 is set
// R10: keying pin outputs receiver subcarrier when bit 6 is set
// R11: keying pin is direct modulation plus receiver reset when bit 5 set; code does so only while bit 6 is clear
// R12: bit 4 picks first or second receiver stage for output
// R13: bits 2 and 3 cut stage gain 6 dB, halve corner frequency
// R14: gain loop observe shows AGC level on main strength bits
// R15: both debug registers reset to zero at power-on or enable low
// R16: decoder or io diag bit enters test mode until stop condition
// R17: a stop condition clears decoder and io diag bits
// R18: coder fast clock bit runs encoders from the carrier clock
// R19: during reception high flag rises once 9 bytes are held
// R20: during transmission low flag rises when only 3 bytes remain
// R21: overflow flag sets when host writes more than FIFO holds
// R22: count field shows unread bytes minus one, bit 7 reads zero
// R23: high and low conditions also raise the level event flag
// R24: strength and FIFO status registers are read-only
`ifndef RSSR_CFG_SVH
`define RSSR_CFG_SVH

`define RSSR_ADDR_STRENGTH 5'h0f
`define RSSR_ADDR_DBG_A    5'h1a
`define RSSR_ADDR_DBG_B    5'h1b
`define RSSR_ADDR_FIFO     5'h1c
`define RSSR_REG_RESET     8'h00

`define RSSR_A_OOK_IN      7
`define RSSR_A_SUBC_OUT    6
`define RSSR_A_DIRECT      5
`define RSSR_A_STAGE_SEL   4
`define RSSR_A_CUT2        3
`define RSSR_A_CUT1        2
`define RSSR_A_FOLLOW      1
`define RSSR_A_AGC_OBS     0
`define RSSR_B_RF_LEVEL    7
`define RSSR_B_IO_HI       3
`define RSSR_B_IO_LO       2
`define RSSR_B_DEC         1
`define RSSR_B_FAST_CLK    0
`define RSSR_B_USED_MASK   8'h8f
`define RSSR_B_DIAG_MASK   8'h0e

`define RSSR_FIFO_DEPTH    4'hc
`define RSSR_FIFO_HIGH     4'h9
`define RSSR_FIFO_LOW      4'h3
`define RSSR_OSC_SETTLE_US 200
`define RSSR_CLK_MHZ       100
`define RSSR_OSC_CYC       (`RSSR_OSC_SETTLE_US * `RSSR_CLK_MHZ)

`endif

// ==== logic/rssr_pkg.sv ====
/*
  Types of the reader status and debug register group.
  Assumes the constants header is available on the include path.
*/
`default_nettype none
package rssr_pkg;
  typedef logic [2:0] rssr_lvl_t;
  typedef struct packed {
    rssr_lvl_t main_env;
    rssr_lvl_t aux_env;
    rssr_lvl_t main_rf;
    rssr_lvl_t aux_rf;
    rssr_lvl_t agc;
  } rssr_levels_s;
  typedef struct packed {
    logic [3:0] bytes;
    logic       host_wr;
    logic       clr;
  } rssr_fifo_s;
  typedef struct packed {
    logic       ook_in;
    logic       subc_out;
    logic       direct;
    logic       stage_sel;
    logic [1:0] gain_cut;
    logic       follow;
    logic       rf_level;
    logic       fast_clk;
  } rssr_dbg_s;
endpackage
`default_nettype wire

// ==== logic/rssr_top.sv ====
/*
  Status and debug register group of the reader front-end: peak-held
  signal strength with oscillator flag, two debug registers that steer
  pins and receiver gain, and the FIFO status register.
  Assumes all inputs are synchronous to i_core_clk, the host register
  port gives one-cycle read and write strobes, and the stop condition
  arrives as a one-cycle pulse from the host interface.
*/
`timescale 1ns/1ps
`default_nettype none
`include "rssr_cfg.svh"

module rssr_top #(
  parameter int unsigned OSC_SETTLE_CYC = `RSSR_OSC_CYC
) (
  // clock and reset
  input  wire logic                 i_core_clk,
  input  wire logic                 i_rst_n,
  input  wire logic                 i_en,
  // host register port
  input  wire logic [4:0]           i_reg_addr,
  input  wire logic                 i_reg_wr,
  input  wire logic                 i_reg_rd,
  input  wire logic [7:0]           i_reg_wdata,
  input  wire logic                 i_stop_cond,
  output logic [7:0]                o_reg_rdata,
  // receiver and transmitter state
  input  wire logic                 i_rx_active,
  input  wire logic                 i_tx_active,
  input  wire logic                 i_rf_level_cmd,
  input  wire logic                 i_input_swap,
  input  wire logic                 i_osc_run,
  input  wire rssr_pkg::rssr_levels_s i_levels,
  // fifo state
  input  wire rssr_pkg::rssr_fifo_s i_fifo,
  output logic                      o_level_event,
  // pins and receiver signals
  input  wire logic                 i_ook_pin,
  input  wire logic                 i_demod_data,
  input  wire logic                 i_rx_subcarrier,
  input  wire logic                 i_keying_pin_in,
  output logic                      o_keying_pin_out,
  output logic                      o_keying_pin_oe,
  output logic                      o_decoder_in,
  output logic                      o_tx_direct_mod,
  output logic                      o_rx_reset,
  // front-end control
  output rssr_pkg::rssr_dbg_s       o_dbg,
  output logic                      o_test_mode
);
  import rssr_pkg::*;

  localparam logic [14:0] OSC_LAST = 15'(OSC_SETTLE_CYC - 1);

  // strength latch and oscillator
  rssr_lvl_t   main_peak;
  rssr_lvl_t   aux_peak;
  logic        tx_seen;
  logic [14:0] osc_cnt;
  logic        osc_ok;
  rssr_lvl_t   next_main_peak;
  rssr_lvl_t   next_aux_peak;
  logic        next_tx_seen;
  logic [14:0] next_osc_cnt;
  logic        next_osc_ok;
  rssr_lvl_t   main_src; // R5
  rssr_lvl_t   aux_src;
  rssr_lvl_t   main_field;

  // strength source: envelope normally, rf amplitude during the command
  always_comb begin
    if (i_rf_level_cmd) begin
      main_src = i_levels.main_rf; // R2
      aux_src  = i_input_swap ? i_levels.main_rf : i_levels.aux_rf; // R8
    end else begin
      main_src = i_levels.main_env; // R2
      aux_src  = i_input_swap ? i_levels.main_env : i_levels.aux_env; // R8
    end
  end

  always_comb begin
    next_main_peak = main_peak;
    next_aux_peak  = aux_peak;
    next_tx_seen   = i_tx_active;
    next_osc_cnt   = osc_cnt;
    next_osc_ok    = osc_ok;
    if (!i_en) begin
      next_main_peak = '0;
      next_aux_peak  = '0;
      next_tx_seen   = 1'b0;
    end else if (i_tx_active && !tx_seen) begin
      // clearing wins over a sample in the same cycle
      next_main_peak = '0; // R4
      next_aux_peak  = '0; // R4
    end else if (i_rx_active || i_rf_level_cmd) begin
      // only the highest code is kept, held after the packet ends
      if (main_src > main_peak) begin
        next_main_peak = main_src; // R3
      end
      if (aux_src > aux_peak) begin
        next_aux_peak = aux_src; // R3
      end
    end
    // outside reception and the rf level command, and before a new transmit, the peaks just hold
    if (!i_osc_run || !i_en) begin
      next_osc_cnt = '0;
      next_osc_ok  = 1'b0;
    end else if (osc_cnt == OSC_LAST) begin
      next_osc_ok = 1'b1; // R7
    end else begin
      next_osc_cnt = osc_cnt + 15'h0001;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      main_peak <= '0;
      aux_peak  <= '0;
      tx_seen   <= 1'b0;
      osc_cnt   <= '0;
      osc_ok    <= 1'b0;
    end else begin
      main_peak <= next_main_peak; // R1
      aux_peak  <= next_aux_peak; // R1
      tx_seen   <= next_tx_seen;
      osc_cnt   <= next_osc_cnt;
      osc_ok    <= next_osc_ok;
    end
  end

  // debug registers
  logic [7:0] dbg_a;
  logic [7:0] dbg_b;
  logic [7:0] next_dbg_a;
  logic [7:0] next_dbg_b;

  always_comb begin
    next_dbg_a = dbg_a;
    next_dbg_b = dbg_b;
    if (i_stop_cond) begin
      next_dbg_b = dbg_b & ~`RSSR_B_DIAG_MASK; // R17
    end
    if (i_reg_wr && i_reg_addr == `RSSR_ADDR_DBG_A) begin
      next_dbg_a = i_reg_wdata;
    end
    // a write in the stop cycle is kept so software can re-arm at once
    if (i_reg_wr && i_reg_addr == `RSSR_ADDR_DBG_B) begin
      next_dbg_b = i_reg_wdata & `RSSR_B_USED_MASK;
    end
    if (!i_en) begin
      next_dbg_a = `RSSR_REG_RESET; // R15
      next_dbg_b = `RSSR_REG_RESET; // R15
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dbg_a <= `RSSR_REG_RESET; // R15
      dbg_b <= `RSSR_REG_RESET; // R15
    end else begin
      dbg_a <= next_dbg_a;
      dbg_b <= next_dbg_b;
    end
  end

  // fifo status
  logic       fifo_high;
  logic       fifo_low;
  logic       fifo_ovf;
  logic       next_fifo_high;
  logic       next_fifo_low;
  logic       next_fifo_ovf;
  logic       next_level_event;
  logic [3:0] fifo_count;

  always_comb begin
    next_fifo_high = i_rx_active && (i_fifo.bytes >= `RSSR_FIFO_HIGH); // R19
    next_fifo_low  = i_tx_active && (i_fifo.bytes <= `RSSR_FIFO_LOW); // R20
    next_fifo_ovf  = fifo_ovf;
    if (i_fifo.clr) begin
      next_fifo_ovf = 1'b0;
    end
    // a write into a full buffer sets, and wins over a clear
    if (i_fifo.host_wr && i_fifo.bytes >= `RSSR_FIFO_DEPTH) begin
      next_fifo_ovf = 1'b1; // R21
    end
    next_level_event = (next_fifo_high && !fifo_high) ||
                       (next_fifo_low && !fifo_low); // R23
    if (!i_en) begin
      next_fifo_high   = 1'b0;
      next_fifo_low    = 1'b0;
      next_fifo_ovf    = 1'b0;
      next_level_event = 1'b0;
    end
  end

  // an empty buffer reads as zero rather than wrapping to all ones
  assign fifo_count = (i_fifo.bytes == 4'h0) ? 4'h0 :
                      i_fifo.bytes - 4'h1; // R22

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fifo_high     <= 1'b0;
      fifo_low      <= 1'b0;
      fifo_ovf      <= 1'b0;
      o_level_event <= 1'b0;
    end else begin
      fifo_high     <= next_fifo_high;
      fifo_low      <= next_fifo_low;
      fifo_ovf      <= next_fifo_ovf;
      o_level_event <= next_level_event; // R23
    end
  end

  // read path; status registers have no write decode at all
  logic [7:0] next_rdata;

  // agc observe replaces only the main field, the latch keeps running
  assign main_field = dbg_a[`RSSR_A_AGC_OBS] ? i_levels.agc
                                              : main_peak; // R14

  always_comb begin
    next_rdata = o_reg_rdata;
    if (i_reg_rd) begin
      unique case (i_reg_addr)
        `RSSR_ADDR_STRENGTH:
          next_rdata = {1'b0, osc_ok, aux_peak, main_field}; // R6 R24
        `RSSR_ADDR_DBG_A:
          next_rdata = dbg_a;
        `RSSR_ADDR_DBG_B:
          next_rdata = dbg_b;
        `RSSR_ADDR_FIFO:
          next_rdata = {1'b0, fifo_high, fifo_low, fifo_ovf,
                        fifo_count}; // R22 R24
        default:
          next_rdata = `RSSR_REG_RESET;
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_reg_rdata <= `RSSR_REG_RESET;
    end else begin
      o_reg_rdata <= next_rdata;
    end
  end

  // pin routing and front-end control, all registered
  logic      next_key_out;
  logic      next_key_oe;
  logic      next_decoder_in;
  logic      next_direct_mod;
  logic      next_rx_reset;
  logic      next_test_mode;
  rssr_dbg_s next_dbg;

  always_comb begin
    next_decoder_in = dbg_a[`RSSR_A_OOK_IN] ? i_ook_pin
                                            : i_demod_data; // R9
    next_key_oe     = dbg_a[`RSSR_A_SUBC_OUT]; // R10
    next_key_out    = dbg_a[`RSSR_A_SUBC_OUT] & i_rx_subcarrier; // R10
    // subcarrier output has priority; direct mode then reads the pin
    next_direct_mod = dbg_a[`RSSR_A_DIRECT] &&
                      !dbg_a[`RSSR_A_SUBC_OUT] && i_keying_pin_in; // R11
    next_rx_reset   = next_direct_mod; // R11
    next_test_mode  = |(dbg_b & `RSSR_B_DIAG_MASK); // R16
    next_dbg.ook_in    = dbg_a[`RSSR_A_OOK_IN];
    next_dbg.subc_out  = dbg_a[`RSSR_A_SUBC_OUT];
    next_dbg.direct    = dbg_a[`RSSR_A_DIRECT];
    next_dbg.stage_sel = dbg_a[`RSSR_A_STAGE_SEL]; // R12
    next_dbg.gain_cut  = {dbg_a[`RSSR_A_CUT2], dbg_a[`RSSR_A_CUT1]}; // R13
    next_dbg.follow    = dbg_a[`RSSR_A_FOLLOW];
    next_dbg.rf_level  = dbg_b[`RSSR_B_RF_LEVEL];
    next_dbg.fast_clk  = dbg_b[`RSSR_B_FAST_CLK]; // R18
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_keying_pin_out <= 1'b0;
      o_keying_pin_oe  <= 1'b0;
      o_decoder_in     <= 1'b0;
      o_tx_direct_mod  <= 1'b0;
      o_rx_reset       <= 1'b0;
      o_test_mode      <= 1'b0;
      o_dbg            <= '0;
    end else begin
      o_keying_pin_out <= next_key_out;
      o_keying_pin_oe  <= next_key_oe;
      o_decoder_in     <= next_decoder_in;
      o_tx_direct_mod  <= next_direct_mod;
      o_rx_reset       <= next_rx_reset;
      o_test_mode      <= next_test_mode; // R16
      o_dbg            <= next_dbg;
    end
  end

endmodule
`default_nettype wire

// ==== test/rssr_host_model.sv ====
/*
  Host controller model: one-cycle register strobes and stop pulses.
  Assumes the bench calls its tasks and wires its outputs to the block.
*/
`timescale 1ns/1ps
`default_nettype none
module rssr_host_model (
  // clock
  input  wire logic  i_core_clk,
  // register port toward the block
  output logic [4:0] o_addr,
  output logic       o_wr,
  output logic       o_rd,
  output logic [7:0] o_wdata,
  output logic       o_stop
);
  initial begin
    {o_addr, o_wr, o_rd, o_wdata, o_stop} = '0;
  end
  // released address and data lines show the inverse so a stale value is never trusted
  task automatic acc(input logic w, input logic [4:0] a,
                     input logic [7:0] d);
    @(posedge i_core_clk);
    {o_addr, o_wdata, o_wr, o_rd} <= {a, d, w, !w};
    @(posedge i_core_clk);
    {o_addr, o_wdata, o_wr, o_rd} <= {~a, ~d, 2'b00};
  endtask
  task automatic stop();
    @(posedge i_core_clk);
    o_stop <= 1'b1;
    @(posedge i_core_clk);
    o_stop <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== test/rssr_top_monitor.sv ====
/*
  Assertion checker of the status and debug register group.
  Assumes it is bound into rssr_top and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
`include "rssr_cfg.svh"
module rssr_monitor (
  // clock and reset
  input wire logic                i_core_clk,
  input wire logic                i_rst_n,
  input wire logic                i_en,
  // host port
  input wire logic [4:0]          i_reg_addr,
  input wire logic                i_reg_wr,
  input wire logic                i_reg_rd,
  input wire logic [7:0]          i_reg_wdata,
  input wire logic                i_stop_cond,
  input wire logic [7:0]          o_reg_rdata,
  input wire logic                o_level_event,
  // pins
  input wire logic                i_ook_pin,
  input wire logic                i_demod_data,
  input wire logic                i_rx_subcarrier,
  input wire logic                i_keying_pin_in,
  input wire logic                o_keying_pin_out,
  input wire logic                o_keying_pin_oe,
  input wire logic                o_decoder_in,
  input wire logic                o_tx_direct_mod,
  input wire logic                o_rx_reset,
  input wire rssr_pkg::rssr_dbg_s o_dbg,
  input wire logic                o_test_mode
);
  import rssr_pkg::*;
  logic up;
  logic next_up;
  logic b_wr;
  assign b_wr = i_reg_wr && i_reg_addr == `RSSR_ADDR_DBG_B;
  // pin routes are judged only after a full enabled cycle
  always_comb next_up = i_en;
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      up <= 1'b0;
    end else begin
      up <= next_up;
    end
  end
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_n);
  sequence s_diag_wr;
    i_en && b_wr && |i_reg_wdata[3:1];
  endsequence
  sequence s_hold;
    i_en && !i_stop_cond && !b_wr;
  endsequence
  chk_diag_enter: assert property (
    s_diag_wr ##1 s_hold |=> o_test_mode)
    else $error("test mode not entered");
  chk_stop_clear: assert property (
    i_stop_cond && !b_wr ##1 !b_wr |=> !o_test_mode)
    else $error("test mode kept after stop");
  chk_en_clear: assert property (
    !i_en ##1 !i_en |=> o_dbg == '0 && !o_test_mode)
    else $error("debug state kept with enable low");
  chk_dec_route: assert property (
    up |-> o_decoder_in ==
      (o_dbg.ook_in ? $past(i_ook_pin) : $past(i_demod_data)))
    else $error("decoder input route wrong");
  chk_subc_drive: assert property (
    up && o_dbg.subc_out |->
      o_keying_pin_oe && o_keying_pin_out == $past(i_rx_subcarrier))
    else $error("subcarrier not on keying pin");
  chk_direct_mod: assert property (
    up && o_dbg.direct && !o_dbg.subc_out |->
      o_tx_direct_mod == $past(i_keying_pin_in) && o_rx_reset == o_tx_direct_mod)
    else $error("direct modulation route wrong");
  chk_rsvd_bits: assert property (
    i_reg_rd && i_reg_addr == `RSSR_ADDR_DBG_B |=> o_reg_rdata[6:4] == 3'h0)
    else $error("unused debug bits read nonzero");
  chk_event_pulse: assert property (
    o_level_event |=> !o_level_event)
    else $error("level event longer than one cycle");
endmodule
bind rssr_top rssr_monitor mon (.*);
`default_nettype wire

// ==== test/test_rssr_top.sv ====
/*
  Self-checking bench of the status and debug register group.
  Assumes the host model drives the register port.
*/
`timescale 1ns/1ps
`default_nettype none
`include "rssr_cfg.svh"
module test_rssr_top;
  import rssr_pkg::*;
  logic         clk, rst_n, en, rx, tx, rfc, swp, osc, wr, rd, stp;
  logic         ook, dem, sub, kin, ev, kout, koe, dec, dmod, rxr, tm;
  logic [4:0]   addr;
  logic [7:0]   wd, rdat, v, m;
  logic [2:0]   xm, xa;
  rssr_levels_s lv, n;
  rssr_fifo_s   ff;
  rssr_dbg_s    dbg;
  logic [31:0]  seed;
  int           error_cnt, cmp_count;
  int           ev_n = 0;
  rssr_host_model host (.i_core_clk(clk), .o_addr(addr), .o_wr(wr),
    .o_rd(rd), .o_wdata(wd), .o_stop(stp));
  rssr_top #(.OSC_SETTLE_CYC(10)) dut (.i_core_clk(clk), .i_rst_n(rst_n),
    .i_en(en), .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_rd(rd),
    .i_reg_wdata(wd), .i_stop_cond(stp), .o_reg_rdata(rdat),
    .i_rx_active(rx), .i_tx_active(tx), .i_rf_level_cmd(rfc),
    .i_input_swap(swp), .i_osc_run(osc), .i_levels(lv), .i_fifo(ff),
    .o_level_event(ev), .i_ook_pin(ook), .i_demod_data(dem),
    .i_rx_subcarrier(sub), .i_keying_pin_in(kin), .o_keying_pin_out(kout),
    .o_keying_pin_oe(koe), .o_decoder_in(dec), .o_tx_direct_mod(dmod),
    .o_rx_reset(rxr), .o_dbg(dbg), .o_test_mode(tm));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) ev_n <= ev_n + int'(ev);
  function automatic logic [7:0] xr();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  function automatic logic [2:0] mx(input logic [2:0] a, b);
    return (a > b) ? a : b;
  endfunction
  function automatic logic [7:0] fexp(input logic [3:0] b,
                                      input logic r, t, o);
    return {1'b0, r && b >= 4'h9, t && b <= 4'h3, o,
            (b == 4'h0) ? 4'h0 : b - 4'h1};
  endfunction
  task automatic cmp(input logic [7:0] g, e);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic rdc(input logic [4:0] a, input logic [7:0] e);
    host.acc(1'b0, a, 8'h00);
    #1;
    cmp(rdat, e);
  endtask
  task automatic results();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    #200_000;
    error_cnt++;
    results();
  end
  initial begin
    {rst_n, en, rx, tx, rfc, swp, osc, ook, dem, sub, kin} = '0;
    {lv, ff} = '0;
    seed = 32'h4bfe_35b8;
    repeat (4) @(posedge clk);
    {rst_n, en, osc} <= 3'b111;
    rdc(`RSSR_ADDR_STRENGTH, 8'h00);
    rdc(`RSSR_ADDR_DBG_A, 8'h00);
    rdc(5'h07, 8'h00);
    repeat (6) begin
      v = xr();
      host.acc(1'b1, `RSSR_ADDR_DBG_A, v);
      // register lands at the strobe edge, the output flop one edge later
      @(posedge clk);
      #1;
      cmp(8'(dbg[8:2]), 8'(v[7:1]));
      rdc(`RSSR_ADDR_DBG_A, v);
    end
    host.acc(1'b1, `RSSR_ADDR_DBG_B, 8'hff);
    @(posedge clk);
    #1;
    cmp(8'({tm, dbg[1:0]}), 8'h07);
    rdc(`RSSR_ADDR_DBG_B, 8'h8f);
    host.stop();
    @(posedge clk);
    #1;
    cmp(8'(tm), 8'h00);
    rdc(`RSSR_ADDR_DBG_B, 8'h81);
    @(posedge clk);
    en <= 1'b0;
    repeat (2) @(posedge clk);
    en <= 1'b1;
    rdc(`RSSR_ADDR_DBG_A, 8'h00);
    rdc(`RSSR_ADDR_DBG_B, 8'h00);
    repeat (12) @(posedge clk);
    // modes: plain, swapped inputs, rf amplitude, gain loop observe
    for (int k = 0; k < 4; k++) begin
      host.acc(1'b1, `RSSR_ADDR_DBG_A, 8'(k == 3));
      @(posedge clk);
      tx <= 1'b1;
      @(posedge clk);
      tx <= 1'b0;
      rdc(`RSSR_ADDR_STRENGTH, {5'h08, (k == 3) ? lv.agc : 3'h0});
      {xm, xa} = '0;
      for (int j = 0; j < 8; j++) begin
        v = xr();
        m = xr();
        n = {v[6:0], m};
        xm = mx(xm, (k == 2) ? n.main_rf : n.main_env);
        xa = mx(xa, (k == 2) ? n.aux_rf : (k == 1) ? n.main_env : n.aux_env);
        @(posedge clk);
        {rx, swp, rfc} <= {1'b1, k == 1, k == 2};
        lv <= n;
      end
      @(posedge clk);
      {rx, rfc} <= 2'b00;
      rdc(`RSSR_ADDR_STRENGTH, {2'b01, xa, (k == 3) ? n.agc : xm});
      host.acc(1'b1, `RSSR_ADDR_STRENGTH, 8'hff);
      rdc(`RSSR_ADDR_STRENGTH, {2'b01, xa, (k == 3) ? n.agc : xm});
    end
    for (int k = 0; k < 8; k++) begin
      host.acc(1'b1, `RSSR_ADDR_DBG_A, {k[2:0], 5'h00});
      repeat (4) begin
        m = xr();
        @(posedge clk);
        {ook, dem, sub, kin} <= m[3:0];
        @(posedge clk);
        #1;
        cmp(8'(dec), 8'(k[2] ? m[3] : m[2]));
        if (k[1]) cmp(8'({koe, kout}), 8'({1'b1, m[1]}));
        else if (k[0]) cmp(8'({dmod, rxr}), 8'({m[0], m[0]}));
      end
    end
    for (int p = 0; p < 2; p++) begin
      for (int b = 0; b < 13; b++) begin
        @(posedge clk);
        {rx, tx} <= {p == 0, p == 1};
        ff.bytes <= 4'(b);
        rdc(`RSSR_ADDR_FIFO, fexp(4'(b), p == 0, p == 1, 1'b0));
      end
    end
    @(posedge clk);
    ff.host_wr <= 1'b1;
    @(posedge clk);
    ff.host_wr <= 1'b0;
    rdc(`RSSR_ADDR_FIFO, fexp(4'hc, 1'b0, 1'b0, 1'b1));
    host.acc(1'b1, `RSSR_ADDR_FIFO, 8'h00);
    rdc(`RSSR_ADDR_FIFO, fexp(4'hc, 1'b0, 1'b0, 1'b1));
    cmp(8'(ev_n > 0), 8'h01);
    results();
  end
endmodule
`default_nettype wire
